// ===== src/rfc_flags_century.sv
/*
  Status flags, control bits and BCD century counter of the clock, behind an AXI4-Lite slave.
  Assumes the alarm comparator, watchdog, power monitor and backup monitor supply one-cycle
  or level events synchronous to core_clk_i, and that rst_i is the power-up reset.
*/
module rfc_flags_century
  import rfc_pkg::*;
#(
  parameter int unsigned CAL_HALF = CAL_HALF_CYC,
  parameter int unsigned OSC_DELAY = OSC_UPD_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire rfc_axi_req_t axi_req_i,
  output rfc_axi_rsp_t axi_rsp_o,
  input wire logic alarm_match_i,
  input wire logic watchdog_zero_i,
  input wire logic power_below_threshold_i,
  input wire logic osc_backup_fail_i,
  input wire logic century_tick_i,
  input wire logic irq_i,
  output logic int_pin_o,
  output logic write_hold_o,
  output logic read_hold_o,
  output logic load_counters_o,
  output logic [7:0] century_o
);

  // The half-period and update timers are 24 bits wide, so larger counts cannot be served.
  if (CAL_HALF < 1 || CAL_HALF > 32'h00ff_ffff || OSC_DELAY < 1 || OSC_DELAY > 32'h00ff_ffff) begin : g_bad_timing
    $error("rfc_flags_century: timing parameter out of range");
  end

  function automatic rfc_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
    if (addr[ADDR_W-1:2] == RTC_STATUS_FLAGS_IDX[ADDR_W-3:0]) begin
      return RFC_SEL_FLAGS;
    end else if (addr[ADDR_W-1:2] == CENTURY_COUNT_IDX[ADDR_W-3:0]) begin
      return RFC_SEL_CENT;
    end
    return RFC_SEL_NONE;
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] != 4'h9) begin
      return {v[7:4], v[3:0] + 4'h1};
    end else if (v[7:4] != 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic have_aw, next_have_aw, have_w, next_have_w;
  logic [ADDR_W-1:0] waddr, next_waddr;
  logic [7:0] wbyte, next_wbyte;
  logic wbyte_en, next_wbyte_en;
  rfc_axi_rsp_t next_rsp;
  logic wr_go, rd_go;
  rfc_sel_t wr_sel, rd_sel;
  logic [7:0] flags_view, cent_view;

  assign wr_go = have_aw && have_w && !axi_rsp_o.bvalid;
  assign wr_sel = reg_decode(waddr);
  assign rd_go = axi_req_i.arvalid && axi_rsp_o.arready;
  assign rd_sel = reg_decode(axi_req_i.araddr);

  always_comb begin
    next_rsp = axi_rsp_o;
    next_have_aw = have_aw;
    next_have_w = have_w;
    next_waddr = waddr;
    next_wbyte = wbyte;
    next_wbyte_en = wbyte_en;
    if (axi_req_i.awvalid && axi_rsp_o.awready) begin
      next_have_aw = 1'b1;
      next_waddr = axi_req_i.awaddr;
      next_rsp.awready = 1'b0;
    end
    if (axi_req_i.wvalid && axi_rsp_o.wready) begin
      next_have_w = 1'b1;
      next_wbyte = axi_req_i.wdata[7:0];
      next_wbyte_en = axi_req_i.wstrb[0];
      next_rsp.wready = 1'b0;
    end
    if (wr_go) begin
      next_have_aw = 1'b0;
      next_have_w = 1'b0;
      next_rsp.bvalid = 1'b1;
      next_rsp.bresp = (wr_sel == RFC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (axi_rsp_o.bvalid && axi_req_i.bready) begin
      next_rsp.bvalid = 1'b0;
      next_rsp.awready = 1'b1;
      next_rsp.wready = 1'b1;
    end
    if (rd_go) begin
      next_rsp.arready = 1'b0;
      next_rsp.rvalid = 1'b1;
      next_rsp.rresp = (rd_sel == RFC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      next_rsp.rdata = '0;
      if (rd_sel == RFC_SEL_FLAGS) begin
        next_rsp.rdata[7:0] = flags_view;
      end else if (rd_sel == RFC_SEL_CENT) begin
        next_rsp.rdata[7:0] = cent_view;
      end
    end
    if (axi_rsp_o.rvalid && axi_req_i.rready) begin
      next_rsp.rvalid = 1'b0;
      next_rsp.arready = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      axi_rsp_o <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
      have_aw <= 1'b0;
      have_w <= 1'b0;
      waddr <= '0;
      wbyte <= 8'h00;
      wbyte_en <= 1'b0;
    end else begin
      axi_rsp_o <= next_rsp;
      have_aw <= next_have_aw;
      have_w <= next_have_w;
      waddr <= next_waddr;
      wbyte <= next_wbyte;
      wbyte_en <= next_wbyte_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, control bits, century counter and calibration output.

  logic watchdog_expired_flag, next_wdf, af, next_af, pf, next_pf, oscillator_fail_flag, next_oscillator_fail_flag;
  logic cal, next_cal, next_whold, next_rhold;
  logic [7:0] next_flags_view, next_cent_view, cent_cnt, next_cent_cnt, cent_stage, next_cent_stage;
  logic [23:0] osc_cnt, next_osc_cnt, cal_cnt, next_cal_cnt;
  logic next_int, next_load;
  logic flags_wr, cent_wr, flags_rd;

  assign flags_wr = wr_go && wbyte_en && wr_sel == RFC_SEL_FLAGS;
  assign cent_wr = wr_go && wbyte_en && wr_sel == RFC_SEL_CENT;
  assign flags_rd = rd_go && rd_sel == RFC_SEL_FLAGS;

  always_comb begin
    // Reads clear only the watchdog, alarm and power bits the reader has actually seen; the osc flag clears on its timer; a new event wins.
    next_wdf = (watchdog_expired_flag && !(flags_rd && flags_view[WATCHDOG_EXPIRED_FLAG_BIT])) || watchdog_zero_i;
    next_af = (af && !(flags_rd && flags_view[ALARM_HIT_FLAG_BIT])) || alarm_match_i;
    next_pf = (pf && !(flags_rd && flags_view[POWER_FAIL_FLAG_BIT])) || power_below_threshold_i;
    next_oscillator_fail_flag = oscillator_fail_flag || osc_backup_fail_i;
    next_osc_cnt = osc_cnt;
    if (osc_cnt != 24'h0) begin
      next_osc_cnt = osc_cnt - 24'h1;
      if (osc_cnt == 24'h1) begin
        next_oscillator_fail_flag = osc_backup_fail_i;
      end
    end
    next_cal = cal;
    next_whold = write_hold_o;
    next_rhold = read_hold_o;
    next_load = 1'b0;
    if (flags_wr) begin
      next_cal = wbyte[CAL_OUT_BIT];
      next_whold = wbyte[WRITE_HOLD_BIT];
      next_rhold = wbyte[READ_HOLD_BIT];
      next_load = write_hold_o && !wbyte[WRITE_HOLD_BIT];
      if (!wbyte[OSCILLATOR_FAIL_FLAG_BIT]) begin
        next_osc_cnt = OSC_DELAY[23:0];
      end
    end
    // Outside write hold the staging byte follows the live count, so a later hold release reloads no stale write.
    next_cent_stage = cent_wr ? wbyte : (write_hold_o ? cent_stage : cent_cnt);
    next_cent_cnt = century_tick_i ? bcd_inc(cent_cnt) : cent_cnt;
    if (cent_wr && !write_hold_o) begin
      next_cent_cnt = wbyte;
    end else if (next_load) begin
      next_cent_cnt = cent_stage;
    end
    next_flags_view = flags_view;
    if (!write_hold_o) begin
      next_flags_view = {watchdog_expired_flag, af, pf, oscillator_fail_flag, 1'b0, cal, write_hold_o, read_hold_o};
    end
    next_flags_view[CAL_OUT_BIT] = next_cal;
    next_flags_view[WRITE_HOLD_BIT] = next_whold;
    next_flags_view[READ_HOLD_BIT] = next_rhold;
    next_cent_view = read_hold_o ? cent_view : cent_cnt;
    next_cal_cnt = 24'h0;
    next_int = irq_i;
    if (cal) begin
      next_int = int_pin_o;
      next_cal_cnt = cal_cnt + 24'h1;
      if (cal_cnt == CAL_HALF[23:0] - 24'h1) begin
        next_cal_cnt = 24'h0;
        next_int = !int_pin_o;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_expired_flag <= 1'b0;
      af <= 1'b0;
      pf <= 1'b0;
      oscillator_fail_flag <= 1'b0;
      osc_cnt <= 24'h0;
      cal <= FLAGS_RST[CAL_OUT_BIT];
      write_hold_o <= FLAGS_RST[WRITE_HOLD_BIT];
      read_hold_o <= FLAGS_RST[READ_HOLD_BIT];
      load_counters_o <= 1'b0;
      flags_view <= FLAGS_RST;
      cent_view <= CENTURY_RST;
      cent_cnt <= CENTURY_RST;
      cent_stage <= CENTURY_RST;
      century_o <= CENTURY_RST;
      cal_cnt <= 24'h0;
      int_pin_o <= 1'b0;
    end else begin
      watchdog_expired_flag <= next_wdf;
      af <= next_af;
      pf <= next_pf;
      oscillator_fail_flag <= next_oscillator_fail_flag;
      osc_cnt <= next_osc_cnt;
      cal <= next_cal;
      write_hold_o <= next_whold;
      read_hold_o <= next_rhold;
      load_counters_o <= next_load;
      flags_view <= next_flags_view;
      cent_view <= next_cent_view;
      cent_cnt <= next_cent_cnt;
      cent_stage <= next_cent_stage;
      century_o <= next_cent_cnt;
      cal_cnt <= next_cal_cnt;
      int_pin_o <= next_int;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking chk_cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  bcd_carry_a: assert property (century_tick_i && !cent_wr && !next_load && cent_cnt == 8'h19
    |=> cent_cnt == 8'h20) else $error("century carry wrong");
  alarm_set_a: assert property (alarm_match_i |=> af) else $error("alarm flag not set");
  alarm_clear_a: assert property (flags_rd && flags_view[ALARM_HIT_FLAG_BIT] && !alarm_match_i
    |=> !af) else $error("alarm flag not cleared by read");
  osc_sticky_a: assert property (oscillator_fail_flag && osc_cnt == 24'h0 |=> oscillator_fail_flag) else $error("osc flag lost");
  osc_delay_a: assert property (osc_cnt > 24'h1 && !osc_backup_fail_i |=> $stable(oscillator_fail_flag))
    else $error("osc flag updated early");
  cal_toggle_a: assert property (cal && cal_cnt == CAL_HALF[23:0] - 24'h1
    |=> int_pin_o != $past(int_pin_o)) else $error("calibration wave not toggling");
  int_normal_a: assert property (!cal |=> int_pin_o == $past(irq_i)) else $error("interrupt not passed");
  whold_load_a: assert property ($fell(write_hold_o) |-> load_counters_o ##1 !load_counters_o)
    else $error("counter load pulse wrong");
  rhold_freeze_a: assert property (read_hold_o && $past(read_hold_o) |-> $stable(cent_view))
    else $error("snapshot moved under read hold");
  wd_set_a: assert property (watchdog_zero_i |=> watchdog_expired_flag ##1 (flags_view[WATCHDOG_EXPIRED_FLAG_BIT] || write_hold_o))
    else $error("watchdog flag not set");
  bresp_hold_a: assert property (axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid)
    else $error("write response dropped");

  cal_mode_c: cover property (cal ##1 $changed(int_pin_o));
  flags_read_c: cover property (flags_rd && flags_view[ALARM_HIT_FLAG_BIT]);
  whold_c: cover property ($fell(write_hold_o));
  osc_clear_c: cover property (osc_cnt == 24'h1);

endmodule // rfc_flags_century

// ===== src/rfc_pkg.sv
/*
  Shared constants and bus carriers for the clock status and century block.
  Assumes a single 200 MHz core clock and an AXI4-Lite master with 32-bit data.
*/
package rfc_pkg;

  // Clock and timing.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CAL_WAVE_HZ = 512;
  localparam int unsigned CAL_HALF_CYC = CLK_HZ / (2 * CAL_WAVE_HZ);
  localparam int unsigned OSC_UPD_DELAY_NS = 1000;
  localparam int unsigned OSC_UPD_CYC = (OSC_UPD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices; the byte address is four times the index.
  localparam int unsigned ADDR_W = 17;
  localparam logic [15:0] RTC_STATUS_FLAGS_IDX = 16'h7ff0;
  localparam logic [15:0] CENTURY_COUNT_IDX = 16'h7ff1;

  // Flag register bit positions.
  localparam int unsigned WATCHDOG_EXPIRED_FLAG_BIT = 7;
  localparam int unsigned ALARM_HIT_FLAG_BIT = 6;
  localparam int unsigned POWER_FAIL_FLAG_BIT = 5;
  localparam int unsigned OSCILLATOR_FAIL_FLAG_BIT = 4;
  localparam int unsigned CAL_OUT_BIT = 2;
  localparam int unsigned WRITE_HOLD_BIT = 1;
  localparam int unsigned READ_HOLD_BIT = 0;

  // Reset values.
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] CENTURY_RST = 8'h00;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RFC_SEL_NONE,
    RFC_SEL_FLAGS,
    RFC_SEL_CENT
  } rfc_sel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } rfc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } rfc_axi_rsp_t;

endpackage

// ===== test/rfc_flags_century_tb.sv
/*
  Self-checking bench for the status flags and century block.
  Assumes rfc_pkg and the host model rfc_host are compiled first.
*/
module rfc_flags_century_tb;
  import rfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [16:0] A_FL = 17'({RTC_STATUS_FLAGS_IDX, 2'b00});
  localparam logic [16:0] A_CE = 17'({CENTURY_COUNT_IDX, 2'b00});
  localparam int CH = 4;
  localparam int OD = 20;
  logic clk = 0, rst = 1, alm = 0, wdg = 0, pwr = 0, osc = 0, tick = 0, irq = 0;
  rfc_axi_req_t req;
  rfc_axi_rsp_t rsp;
  logic iq, wh, rh, ld;
  logic [7:0] cen, d;
  logic [1:0] r;
  logic [31:0] seed = 32'd70;
  int failures = 0, n_tests = 0, cyc = 0, m, k;
  rfc_flags_century #(.CAL_HALF(CH), .OSC_DELAY(OD)) dut (.core_clk_i(clk), .rst_i(rst), .axi_req_i(req),
    .axi_rsp_o(rsp), .alarm_match_i(alm), .watchdog_zero_i(wdg), .power_below_threshold_i(pwr),
    .osc_backup_fail_i(osc), .century_tick_i(tick), .irq_i(irq), .int_pin_o(iq), .write_hold_o(wh),
    .read_hold_o(rh), .load_counters_o(ld), .century_o(cen));
  rfc_host host (.clk_i(clk), .req_o(req), .rsp_i(rsp));
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int inc(input int v);
    if ((v & 15) != 9) return v + 1;
    return (v >> 4) == 9 ? 0 : ((v >> 4) + 1) << 4;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    case (i)
      0: wdg <= 1'b1;
      1: alm <= 1'b1;
      2: pwr <= 1'b1;
      3: osc <= 1'b1;
      default: tick <= 1'b1;
    endcase
    @(posedge clk);
    {wdg, alm, pwr, osc, tick} <= '0;
  endtask
  ////////////////////////////////////////
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report;
    end
  end
  initial begin
    cy(8);
    rst <= 1'b0;
    host.rd(A_FL, d, r);
    chk("flags_rst", d, FLAGS_RST);
    chk("rd_okay", r, RESP_OKAY);
    host.rd(A_CE, d, r);
    chk("cent_rst", d, CENTURY_RST);
    $display("test reset done");
    for (k = 0; k < 3; k++) begin
      pulse(k);
      cy(3);
      host.rd(A_FL, d, r);
      chk("flag_set", d, 8'h80 >> k);
      host.rd(A_FL, d, r);
      chk("flag_clr", d, 8'h00);
    end
    $display("test events done");
    pulse(3);
    cy(3);
    host.rd(A_FL, d, r);
    chk("osc_set", d[4], 1'b1);
    host.rd(A_FL, d, r);
    chk("osc_keep", d[4], 1'b1);
    host.wr(A_FL, 8'h00, r);
    chk("wr_okay", r, RESP_OKAY);
    host.rd(A_FL, d, r);
    chk("osc_early", d[4], 1'b1);
    cy(OD + 4);
    host.rd(A_FL, d, r);
    chk("osc_clr", d[4], 1'b0);
    $display("test osc done");
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      m = k == 0 ? 'h99 : k == 1 ? 'h09 : int'(seed % 10) * 16 + int'((seed >> 8) % 10);
      host.wr(A_CE, 8'(m), r);
      cy(2);
      pulse(4);
      cy(2);
      chk("cent_inc", cen, 8'(inc(m)));
      host.rd(A_CE, d, r);
      chk("cent_rd", d, 8'(inc(m)));
    end
    $display("test century done");
    host.wr(A_FL, 8'h04, r);
    k = iq;
    m = 0;
    while (iq === k && m < 4 * CH) begin
      @(posedge clk);
      m++;
    end
    k = iq;
    m = 0;
    do begin
      @(posedge clk);
      m++;
    end while (iq === k && m < 4 * CH);
    chk("cal_half", m, CH);
    host.wr(A_FL, 8'h00, r);
    cy(CH + 2);
    repeat (4) begin
      seed = xs(seed);
      irq <= seed[0];
      cy(2);
      chk("int_irq", iq, seed[0]);
    end
    $display("test cal done");
    host.wr(A_FL, 8'h02, r);
    cy(1);
    chk("w_hold", wh, 1'b1);
    pulse(1);
    cy(3);
    host.rd(A_FL, d, r);
    chk("af_frozen", d, 8'h02);
    m = cen;
    host.wr(A_CE, 8'h42, r);
    cy(3);
    chk("cent_frozen", cen, 8'(m));
    k = 0;
    fork
      host.wr(A_FL, 8'h00, r);
      repeat (12) begin
        @(posedge clk);
        if (ld === 1'b1) k++;
      end
    join
    chk("load_pulse", k, 1);
    chk("cent_load", cen, 8'h42);
    host.rd(A_FL, d, r);
    chk("af_release", d, 8'h40);
    host.wr(A_FL, 8'h01, r);
    cy(1);
    chk("r_hold", rh, 1'b1);
    pulse(4);
    cy(2);
    host.rd(A_CE, d, r);
    chk("snap", d, 8'h42);
    chk("live", cen, 8'h43);
    host.wr(A_FL, 8'h00, r);
    cy(2);
    host.rd(A_CE, d, r);
    chk("snap_go", d, 8'h43);
    host.rd(17'h00010, d, r);
    chk("unmapped", r, RESP_SLVERR);
    host.wr(17'h00010, 8'h00, r);
    chk("unmapped_wr", r, RESP_SLVERR);
    $display("test hold done");
    final_report;
  end
endmodule // rfc_flags_century_tb

// ===== test/rfc_host.sv
/*
  Host model: an AXI4-Lite master offering one write task and one read task.
  Assumes the slave answers every request; the bench bounds any wait.
*/
module rfc_host
  import rfc_pkg::*;
(
  input wire logic clk_i,
  output rfc_axi_req_t req_o,
  input wire rfc_axi_rsp_t rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  // Released payloads show the inverse so a slave cannot lean on stale values.
  task automatic wr(input logic [16:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk_i);
    req_o.awaddr <= a;
    req_o.awvalid <= 1'b1;
    req_o.wdata <= {24'h0, d};
    req_o.wstrb <= 4'hf;
    req_o.wvalid <= 1'b1;
    req_o.bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (aw && rsp_i.awready) begin
        aw = 1'b0;
        req_o.awvalid <= 1'b0;
        req_o.awaddr <= ~a;
      end
      if (w && rsp_i.wready) begin
        w = 1'b0;
        req_o.wvalid <= 1'b0;
        req_o.wdata <= ~{24'h0, d};
      end
    end while (!rsp_i.bvalid);
    r = rsp_i.bresp;
    req_o.bready <= 1'b0;
  endtask
  task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk_i);
    req_o.araddr <= a;
    req_o.arvalid <= 1'b1;
    req_o.rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (req_o.arvalid && rsp_i.arready) begin
        req_o.arvalid <= 1'b0;
        req_o.araddr <= ~a;
      end
    end while (!rsp_i.rvalid);
    d = rsp_i.rdata[7:0];
    r = rsp_i.rresp;
    req_o.rready <= 1'b0;
  endtask
endmodule // rfc_host
